/* rtl/pcrl_pkg.sv */
// Constants, register map and field layout of the configuration row store
package pcrl_pkg;
   // ------------------------------------------------------------------
   // Row address map
   // ------------------------------------------------------------------
   localparam int         ROW_W          = 6;        // Row address width
   localparam int         ARRAY_ROWS     = 32;       // Logic array rows 0..31
   localparam int         ROW_BITS       = 64;       // Bits per array/signature row
   localparam int         ACW_BITS       = 82;       // Architecture control word width
   localparam logic [5:0] ROW_SIG        = 6'h20;    // Signature row 32
   localparam logic [5:0] ROW_RSV_LO     = 6'h21;    // First maker row 33
   localparam logic [5:0] ROW_RSV_HI     = 6'h3B;    // Last maker row 59
   localparam logic [5:0] ROW_ACW        = 6'h3C;    // Control word row 60
   localparam logic [5:0] ROW_SEC        = 6'h3D;    // Security cell row 61
   localparam logic [5:0] ROW_SPARE      = 6'h3E;    // Unassigned row 62, refused
   localparam logic [5:0] ROW_ERASE      = 6'h3F;    // Bulk erase row 63
   localparam logic       ERASED_BIT     = 1'b0;     // Virgin cell value
   localparam logic [63:0] LOCKED_WORD   = 64'hA5A5_A5A5_A5A5_A5A5; // Read of locked rows
   // ------------------------------------------------------------------
   // Control word fields
   // ------------------------------------------------------------------
   localparam int POL_LSB   = 0;   // Eight polarity bits [7:0]
   localparam int CELL_LSB  = 8;   // Per-cell configuration bits [15:8]
   localparam int MODE0_BIT = 16;  // Mode select bit zero
   localparam int REGSEL_BIT = 17; // Mode select bit one; set with bit zero selects complex
   localparam int N_CELLS   = 8;   // Output macrocells
   typedef enum logic [1:0] {PCRL_SIMPLE, PCRL_COMPLEX, PCRL_REGISTERED} pcrl_mode_t;
   // ------------------------------------------------------------------
   // APB register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_ROW    = 8'h00;  // Row address
   localparam logic [7:0] OFS_CMD    = 8'h04;  // Command strobes
   localparam logic [7:0] OFS_DATA0  = 8'h08;  // Row data bits 31:0
   localparam logic [7:0] OFS_DATA1  = 8'h0C;  // Row data bits 63:32
   localparam logic [7:0] OFS_DATA2  = 8'h10;  // Row data bits 81:64
   localparam logic [7:0] OFS_STATUS = 8'h14;  // Status
   localparam logic [7:0] OFS_OUTQ   = 8'h18;  // Output register states
   localparam int CMD_PROG_BIT = 0;            // Program row
   localparam int CMD_READ_BIT = 1;            // Verify row into data
   localparam int ST_DONE_BIT  = 0;            // Power-up reset finished
   localparam int ST_SEC_BIT   = 1;            // Security cell programmed
   localparam int ST_ERR_BIT   = 2;            // Refused row access (sticky)
   localparam int ST_PRE_BIT   = 3;            // Preload mode active
   localparam int ST_MODE_LSB  = 4;            // Macrocell mode, 2 bits
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;         // CORE_CLK period
   localparam int RESET_TIME_US = 10;          // Power-up reset time
   localparam int RESET_CYCLES  = (RESET_TIME_US * 1000) / CLK_PERIOD_NS; // Longest: floor
endpackage

/* rtl/pcrl_core.sv */
// Configuration row store, register preload and power-up reset
`timescale 1ns/100ps
// Functional notes
// - 32 array rows of 64 bits
// - Row 32 holds user signature word
// - Rows 33-59 refused for program and read
// - Row 60 holds 82-bit control word
// - Eight independent output polarity bits
// - Security cell blocks array row readback
// - Signature readable regardless of security
// - Security cleared only by bulk erase or RST
// - Row 63 program erases everything
// - Preload forces register states synchronously
// - High-voltage pin enables serial buffers
// - One bit per shift clock rise
// - Only registered cells join chain
// - Chain fills from bottom upward
// - Power-up reset clears registers in 10us
// - Reset registered pins show high
// - One mode shared by all cells
// - Common enable for registered outputs
module pcrl_core (
   input  wire logic        CORE_CLK,       // Core clock
   input  wire logic        RST,            // Asynchronous reset, high
   input  wire logic        PSEL,           // APB select
   input  wire logic        PENABLE,        // APB enable
   input  wire logic        PWRITE,         // APB direction
   input  wire logic [7:0]  PADDR,          // APB byte address
   input  wire logic [31:0] PWDATA,         // APB write data
   output logic             PREADY,         // APB ready
   output logic [31:0]      PRDATA,         // APB read data
   output logic             PSLVERR,        // APB error
   input  wire logic        PRELOAD_HIGH_VOLTAGE_PIN, // Preload entry level
   input  wire logic        PRELOAD_SHIFT_CLOCK,      // Tester shift clock
   input  wire logic        SERIAL_PRELOAD_IN,        // Tester serial data
   output logic             SERIAL_PRELOAD_OUT,       // Serial data out
   output logic             SERIAL_PRELOAD_OUT_EN,    // Serial out buffer enable
   input  wire logic [7:0]  NEXT_STATE_IN,  // Sum terms to registers
   input  wire logic [7:0]  COMB_TERM_IN,   // Sum terms of combinational cells
   input  wire logic [7:0]  TERM_OE_IN,     // Per-cell enable product terms
   input  wire logic        OE_N_IN,        // Common output enable, low
   output logic [7:0]       OUT_PIN,        // Macrocell output values
   output logic [7:0]       OUT_EN          // Macrocell output enables
);
   import pcrl_pkg::*;

   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------
   // One mode for the whole device; the unused code falls back to simple
   function automatic pcrl_mode_t mode_of(input logic [ACW_BITS-1:0] w);
      if (!w[REGSEL_BIT] && w[MODE0_BIT])
         return PCRL_REGISTERED;
      else if (w[REGSEL_BIT] && w[MODE0_BIT])
         return PCRL_COMPLEX;
      else
         return PCRL_SIMPLE;
   endfunction

   // Cells acting as registers: registered mode and config bit clear
   function automatic logic [N_CELLS-1:0] reg_mask(input logic [ACW_BITS-1:0] w);
      if (mode_of(w) == PCRL_REGISTERED)
         return ~w[CELL_LSB +: N_CELLS];
      else
         return '0;
   endfunction

   // Rows that software may not touch: maker rows and the spare row
   function automatic logic is_reserved(input logic [ROW_W-1:0] r);
      return (r >= ROW_RSV_LO && r <= ROW_RSV_HI) || r == ROW_SPARE;
   endfunction

   // ------------------------------------------------------------------
   // Storage and state
   // ------------------------------------------------------------------
   logic [ROW_BITS-1:0] array_row [ARRAY_ROWS]; // Logic array, not reset
   logic [ROW_BITS-1:0] signature;              // User signature word
   logic [ACW_BITS-1:0] acw;                    // Architecture control word
   logic                secure;                 // Security cell
   logic [ROW_W-1:0]    row_addr;               // Selected row
   logic [ACW_BITS-1:0] data_buf;               // Row data staging
   logic                refused;                // Sticky refusal flag
   logic [N_CELLS-1:0]  q;                      // Output registers
   logic [7:0]          rst_cnt;                // Power-up reset counter
   logic                rst_done;               // Registers may clock
   logic [2:0]          hv_sync, sck_sync, sdi_sync; // Pin synchronisers
   logic                hv_stable, sck_stable, sdi_stable; // Filtered levels
   logic                sck_rise;               // Shift clock rising edge
   logic                wr_en, rd_en;           // APB write completing, read in wait state
   logic                prog_stb, read_stb;     // Command strobes
   logic [N_CELLS-1:0]  regd;                   // Registered cell mask
   pcrl_mode_t          mode;                   // Current device mode

   assign mode     = mode_of(acw);
   assign regd     = reg_mask(acw);
   assign wr_en    = PSEL && PENABLE && PREADY && PWRITE;
   assign rd_en    = PSEL && PENABLE && !PREADY && !PWRITE;
   assign prog_stb = wr_en && PADDR == OFS_CMD && PWDATA[CMD_PROG_BIT];
   assign read_stb = wr_en && PADDR == OFS_CMD && PWDATA[CMD_READ_BIT];

   // ------------------------------------------------------------------
   // APB slave: one wait state, ready and data from flip-flops
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= '0;
         PSLVERR <= 1'b0;
      end else if (PSEL && PENABLE && !PREADY) begin
         PREADY  <= 1'b1;
         PSLVERR <= !(PADDR inside {OFS_ROW, OFS_CMD, OFS_DATA0, OFS_DATA1,
                                    OFS_DATA2, OFS_STATUS, OFS_OUTQ});
         PRDATA  <= '0;
         if (rd_en) begin
            unique case (PADDR)
               OFS_ROW:    PRDATA <= {26'h0, row_addr};
               OFS_DATA0:  PRDATA <= data_buf[31:0];
               OFS_DATA1:  PRDATA <= data_buf[63:32];
               OFS_DATA2:  PRDATA <= {14'h0, data_buf[ACW_BITS-1:64]};
               OFS_STATUS: PRDATA <= {26'h0, mode, hv_stable, refused, secure, rst_done};
               OFS_OUTQ:   PRDATA <= {24'h0, q};
               default:    PRDATA <= '0;   // Command and unmapped read zero
            endcase
         end
      end else begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // Row address register
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST)
         row_addr <= '0;
      else if (wr_en && PADDR == OFS_ROW)
         row_addr <= PWDATA[ROW_W-1:0];
   end

   // ------------------------------------------------------------------
   // Data staging: software writes, verify reads fill it
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         data_buf <= '0;
      end else if (read_stb) begin
         data_buf <= '0;
         if (row_addr < ROW_SIG) begin
            if (secure)
               data_buf[63:0] <= LOCKED_WORD;
            else
               data_buf[63:0] <= array_row[row_addr[4:0]];
         end else if (row_addr == ROW_SIG)
            data_buf[63:0] <= signature;
         else if (row_addr == ROW_ACW)
            data_buf <= acw;
         else if (row_addr == ROW_SEC)
            data_buf[0] <= secure;
      end else if (wr_en) begin
         if (PADDR == OFS_DATA0) data_buf[31:0] <= PWDATA;
         if (PADDR == OFS_DATA1) data_buf[63:32] <= PWDATA;
         if (PADDR == OFS_DATA2) data_buf[ACW_BITS-1:64] <= PWDATA[17:0];
      end
   end

   // Refusal flag: a new refusal wins over a clear of the same cycle
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST)
         refused <= 1'b0;
      else if ((prog_stb || read_stb) && is_reserved(row_addr))
         refused <= 1'b1;
      else if (wr_en && PADDR == OFS_STATUS && PWDATA[ST_ERR_BIT])
         refused <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Nonvolatile rows: program and bulk erase
   // ------------------------------------------------------------------
   // The array keeps no reset, as a real store would; erase it first
   always_ff @(posedge CORE_CLK) begin
      if (prog_stb && row_addr == ROW_ERASE) begin
         for (int i = 0; i < ARRAY_ROWS; i++)
            array_row[i] <= {ROW_BITS{ERASED_BIT}};
      end else if (prog_stb && row_addr < ROW_SIG)
         array_row[row_addr[4:0]] <= data_buf[63:0];
   end

   // Signature, control word and security cell
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         signature <= {ROW_BITS{ERASED_BIT}};
         acw       <= {ACW_BITS{ERASED_BIT}};
         secure    <= ERASED_BIT;
      end else if (prog_stb) begin
         unique case (row_addr)
            ROW_ERASE: begin
               signature <= {ROW_BITS{ERASED_BIT}};
               acw       <= {ACW_BITS{ERASED_BIT}};
               secure    <= ERASED_BIT;
            end
            ROW_SIG:   signature <= data_buf[63:0];
            ROW_ACW:   acw <= data_buf;
            ROW_SEC:   secure <= secure | data_buf[0];
            default:   ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Power-up reset timer
   // ------------------------------------------------------------------
   // Output register clocks before expiry are ignored, so an early edge cannot upset q
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         rst_cnt  <= '0;
         rst_done <= 1'b0;
      end else if (!rst_done) begin
         rst_cnt  <= rst_cnt + 8'h01;
         rst_done <= (rst_cnt == 8'(RESET_CYCLES - 1));
      end
   end

   // ------------------------------------------------------------------
   // Preload pin synchronisers: change taken when stages two and three agree
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         hv_sync  <= '0;
         sck_sync <= '0;
         sdi_sync <= '0;
      end else begin
         hv_sync  <= {hv_sync[1:0], PRELOAD_HIGH_VOLTAGE_PIN};
         sck_sync <= {sck_sync[1:0], PRELOAD_SHIFT_CLOCK};
         sdi_sync <= {sdi_sync[1:0], SERIAL_PRELOAD_IN};
      end
   end

   // Filtered levels
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         hv_stable  <= 1'b0;
         sck_stable <= 1'b0;
         sdi_stable <= 1'b0;
      end else begin
         if (hv_sync[1] == hv_sync[2])   hv_stable  <= hv_sync[2];
         if (sck_sync[1] == sck_sync[2]) sck_stable <= sck_sync[2];
         if (sdi_sync[1] == sdi_sync[2]) sdi_stable <= sdi_sync[2];
      end
   end

   assign sck_rise = hv_stable && !sck_stable &&
                     sck_sync[1] == sck_sync[2] && sck_sync[2];

   // ------------------------------------------------------------------
   // Output registers: reset, preload chain, normal capture
   // ------------------------------------------------------------------
   // Chain runs through registered cells only, bit enters the bottom cell
   always_ff @(posedge CORE_CLK or posedge RST) begin
      logic carry;
      carry = 1'b0;
      if (RST) begin
         q                  <= '0;
         SERIAL_PRELOAD_OUT <= 1'b0;
      end else if (!rst_done) begin
         q                  <= '0;
         SERIAL_PRELOAD_OUT <= 1'b0;
      end else if (hv_stable) begin
         if (sck_rise) begin
            carry = sdi_stable;
            for (int i = 0; i < N_CELLS; i++) begin
               if (regd[i]) begin
                  q[i]  <= carry;
                  carry = q[i];
               end
            end
            SERIAL_PRELOAD_OUT <= carry;
         end
      end else begin
         q <= (q & ~regd) | (NEXT_STATE_IN & regd);
      end
   end

   // Serial out buffer enabled only with the entry level present
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST)
         SERIAL_PRELOAD_OUT_EN <= 1'b0;
      else
         SERIAL_PRELOAD_OUT_EN <= hv_stable;
   end

   // ------------------------------------------------------------------
   // Output pins and enables
   // ------------------------------------------------------------------
   // Registered pins show the inverted register, so a reset reads high
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         OUT_PIN <= '0;
         OUT_EN  <= '0;
      end else begin
         for (int i = 0; i < N_CELLS; i++) begin
            if (regd[i]) begin
               OUT_PIN[i] <= ~q[i];
               OUT_EN[i]  <= !OE_N_IN;
            end else begin
               OUT_PIN[i] <= COMB_TERM_IN[i] ^ acw[POL_LSB + i];
               OUT_EN[i]  <= (mode == PCRL_SIMPLE) ? 1'b1 : TERM_OE_IN[i];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_read_arr;
      read_stb && row_addr < ROW_SIG && secure;
   endsequence

   a_locked_read:  assert property (s_read_arr |=> data_buf[63:0] == LOCKED_WORD)
      else $error("locked array row read back");
   a_sig_read:     assert property (read_stb && row_addr == ROW_SIG
                                    |=> data_buf[63:0] == $past(signature))
      else $error("signature not returned");
   a_erase_all:    assert property (prog_stb && row_addr == ROW_ERASE
                                    |=> !secure && acw == '0 && signature == '0)
      else $error("bulk erase incomplete");
   a_sec_sticky:   assert property ($fell(secure) |-> $past(prog_stb)
                                    && $past(row_addr) == ROW_ERASE)
      else $error("security cleared without erase");
   a_reserved:     assert property ((prog_stb || read_stb) && is_reserved(row_addr)
                                    |=> refused && $stable(acw))
      else $error("reserved row not refused");
   a_reset_time:   assert property ($rose(rst_done) |-> rst_cnt == 8'(RESET_CYCLES)
                                    && q == '0)
      else $error("power-up reset time wrong");
   a_reset_pin:    assert property (regd[0] && !q[0] |=> OUT_PIN[0])
      else $error("registered pin low after reset");
   a_shift_bottom: assert property (sck_rise && !$past(RST) && regd[0]
                                    |=> q[0] == $past(sdi_stable))
      else $error("preload bit not in bottom cell");
   a_unreg_hold:   assert property (hv_stable && !regd[1] && rst_done |=> $stable(q[1]))
      else $error("unregistered cell shifted");
   a_ser_en:       assert property (hv_stable |=> SERIAL_PRELOAD_OUT_EN)
      else $error("serial out buffer not enabled");
   a_common_oe:    assert property (regd[2] && $stable(regd) |=> OUT_EN[2] == !$past(OE_N_IN))
      else $error("registered enable not common");
endmodule

/* tb/pcrl_tester.sv */
// Programmer and test vector model driving the preload pins
`timescale 1ns/100ps
module pcrl_tester (
   input  wire logic clk,
   output logic      hv_pin,
   output logic      shift_clk,
   output logic      sdi
);
   // Idle: no entry voltage, shift clock stands still between bits
   initial begin
      hv_pin    = 1'b0;
      shift_clk = 1'b0;
      sdi       = 1'b1;
   end
   // Raise or drop the entry level, then let the pin filter settle
   task automatic entry(input logic on);
      @(posedge clk) hv_pin <= on;
      repeat (6) @(posedge clk);
   endtask
   // One bit per rise; data held well around the edge for the sampler
   task automatic shift(input logic b);
      @(posedge clk) sdi <= b;
      repeat (5) @(posedge clk);
      shift_clk <= 1'b1;
      repeat (5) @(posedge clk);
      shift_clk <= 1'b0;
      repeat (5) @(posedge clk);
      sdi <= ~b; // No stale value once the hold has run out
   endtask
endmodule

/* tb/pld_config_rows_preload_reset_test.sv */
// Self-checking bench for the configuration row store
`timescale 1ns/100ps
module pld_config_rows_preload_reset_test;
   import pcrl_pkg::*;
   logic        clk, pready, pslverr, err, hv, sclk, sdi, sdo, sdo_en;
   logic        rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, oe_n = 1'b1;
   logic [7:0]  paddr = 8'h0, nxt = 8'h0, comb = 8'h0, toe = 8'h0, out_pin, out_en, pol, rm;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [81:0] d, q, sig;
   logic [3:0]  b;
   logic [1:0]  codes[4] = '{2'b00, 2'b11, 2'b10, 2'b01};
   logic [5:0]  rows[3] = '{6'h00, 6'h1F, ROW_SIG};
   logic [5:0]  rsv[3] = '{ROW_RSV_LO, ROW_RSV_HI, 6'h3E};
   logic [5:0]  erased[3] = '{6'h05, ROW_SIG, ROW_ACW};
   int          miscompares = 0, compares = 0, k;
   pcrl_core u_dut (
      .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .PRELOAD_HIGH_VOLTAGE_PIN(hv), .PRELOAD_SHIFT_CLOCK(sclk), .SERIAL_PRELOAD_IN(sdi),
      .SERIAL_PRELOAD_OUT(sdo), .SERIAL_PRELOAD_OUT_EN(sdo_en), .NEXT_STATE_IN(nxt),
      .COMB_TERM_IN(comb), .TERM_OE_IN(toe), .OE_N_IN(oe_n), .OUT_PIN(out_pin),
      .OUT_EN(out_en));
   pcrl_tester u_tester (.clk(clk), .hv_pin(hv), .shift_clk(sclk), .sdi(sdi));
   // 10 MHz core clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [81:0] got, input logic [81:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // APB transfer: request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++)
         @(posedge clk);
      if (n == 20) begin
         miscompares++;
         stop_test();
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic prog(input logic [5:0] r);
      apb(1'b1, OFS_ROW, {26'h0, r});
      apb(1'b1, OFS_DATA0, d[31:0]);
      apb(1'b1, OFS_DATA1, d[63:32]);
      apb(1'b1, OFS_DATA2, {14'h0, d[81:64]});
      apb(1'b1, OFS_CMD, 32'h1);
   endtask
   task automatic rdrow(input logic [5:0] r);
      apb(1'b1, OFS_ROW, {26'h0, r});
      apb(1'b1, OFS_CMD, 32'h2);
      apb(1'b0, OFS_DATA0, 32'h0);
      q[31:0] = rd;
      apb(1'b0, OFS_DATA1, 32'h0);
      q[63:32] = rd;
      apb(1'b0, OFS_DATA2, 32'h0);
      q[81:64] = rd[17:0];
   endtask
   // Mode code from the two select bits; only 01 and 11 leave simple mode
   function automatic logic [1:0] exp_mode(input logic [1:0] c);
      return (c == 2'b01) ? 2'd2 : (c == 2'b11) ? 2'd1 : 2'd0;
   endfunction
   // Simple mode always drives; registered cells follow the common enable
   function automatic logic [7:0] exp_en(input logic [1:0] m, input logic [7:0] r);
      return (m == 2'd0) ? 8'hFF : ((r & {8{~oe_n}}) | (~r & toe));
   endfunction
   initial begin
      void'($urandom(32'hAA24));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[ST_DONE_BIT], 1'b0, "done early");
      // Nothing but polling until done, so no register sees an early clock
      for (k = 0; k < 60 && rd[ST_DONE_BIT] !== 1'b1; k++)
         apb(1'b0, OFS_STATUS, 32'h0);
      // Each poll spans four core cycles
      chk(k >= RESET_CYCLES / 4 - 1 && k <= RESET_CYCLES / 4 + 1, 1'b1, "reset time");
      apb(1'b0, OFS_OUTQ, 32'h0);
      chk(rd[7:0], 8'h00, "q after reset");
      foreach (rows[i]) begin
         d = {18'h0, $urandom, $urandom};
         prog(rows[i]);
         rdrow(rows[i]);
         chk(q[63:0], d[63:0], "row data");
      end
      sig = d;
      // Walk every mode code; registered cells 0, 2 and 5 in registered mode
      foreach (codes[i]) begin
         d = 82'({$urandom, $urandom, $urandom});
         d[17:8] = {codes[i], 8'hDA};
         pol = d[7:0];
         prog(ROW_ACW);
         rdrow(ROW_ACW);
         chk(q, d, "control word");
         apb(1'b0, OFS_STATUS, 32'h0);
         chk(rd[ST_MODE_LSB +: 2], exp_mode(codes[i]), "mode");
         rm = (exp_mode(codes[i]) == 2'd2) ? 8'h25 : 8'h00;
         comb <= 8'($urandom);
         toe  <= 8'($urandom);
         oe_n <= 1'($urandom);
         repeat (3) @(posedge clk);
         chk(out_pin & ~rm, (comb ^ pol) & ~rm, "polarity");
         chk(out_en, exp_en(exp_mode(codes[i]), rm), "enable");
      end
      nxt <= 8'($urandom);
      b = 4'($urandom);
      u_tester.entry(1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({rd[ST_PRE_BIT], sdo_en}, 2'b11, "preload entry");
      for (int i = 0; i < 3; i++)
         u_tester.shift(b[i]);
      apb(1'b0, OFS_OUTQ, 32'h0);
      chk(rd[7:0] & 8'h25, {2'b0, b[0], 2'b0, b[1], 1'b0, b[2]}, "chain");
      chk(out_pin & 8'h25, ~rd[7:0] & 8'h25, "reg pin");
      u_tester.shift(b[3]);
      chk(sdo, b[0], "shift out");
      u_tester.entry(1'b0);
      // Lock, try to unlock by programming, then bulk erase
      d = {18'h0, $urandom, $urandom};
      prog(6'h05);
      d = 82'h1;
      prog(ROW_SEC);
      d = 82'h0;
      prog(ROW_SEC);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[ST_SEC_BIT], 1'b1, "secure");
      rdrow(6'h05);
      chk(q[63:0], LOCKED_WORD, "locked read");
      rdrow(ROW_SIG);
      chk(q[63:0], sig[63:0], "signature");
      prog(ROW_ERASE);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[ST_SEC_BIT], 1'b0, "erase secure");
      foreach (erased[i]) begin
         rdrow(erased[i]);
         chk(q[63:0], 64'h0, "erased");
      end
      foreach (rsv[i]) begin
         apb(1'b1, OFS_STATUS, 32'h4);
         prog(rsv[i]);
         apb(1'b0, OFS_STATUS, 32'h0);
         chk(rd[ST_ERR_BIT], 1'b1, "refused");
         rdrow(rsv[i]);
         chk(q[63:0], 64'h0, "refused read");
      end
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1, "unmapped");
      stop_test();
   end
endmodule
